// [acwl_pkg.sv]
/*
 Package for the converter setup word loader: field positions, codes and timing.
 Assumes a 25 MHz system clock; serial pins are asynchronous to it.
*/
package acwl_pkg;
	localparam int WORD_W = 14;
	localparam int QUAL_BIT = 13;
	localparam int ARR_HI = 12;
	localparam int ARR_LO = 10;
	localparam int CH_HI = 9;
	localparam int CH_LO = 7;
	localparam int FW_BIT = 6;
	localparam int REF_HI = 5;
	localparam int REF_LO = 3;
	localparam int SCAN_HI = 2;
	localparam int SCAN_LO = 1;
	localparam int ECHO_BIT = 0;
	localparam logic [13:0] DEFAULT_WORD = 14'h3fff;
	localparam logic [13:0] RESET_WORD = 14'h3fff;
	localparam logic [2:0] ARR_TEMP = 3'h3;
	localparam logic [2:0] ARR_BI_COM = 3'h2;
	localparam logic [2:0] ARR_UNI_COM = 3'h6;
	localparam logic [2:0] ARR_SINGLE = 3'h7;
	localparam logic [2:0] CH_LAST = 3'h7;
	localparam logic [2:0] CH_ZERO = 3'h0;
	localparam logic [1:0] SCAN_OFF = 2'h0;
	localparam logic [1:0] SCAN_UPD = 2'h1;
	localparam logic [1:0] SCAN_TEMP = 2'h2;
	localparam logic [1:0] SCAN_PLAIN = 2'h3;
	localparam logic [3:0] BITS_LAST = 4'hd;
	localparam logic [3:0] BITS_ZERO = 4'h0;
	localparam int CLK_MHZ = 25;
	localparam int CONV_NS = 2200;
	localparam int CONV_CYC = (CONV_NS * CLK_MHZ + 999) / 1000;
	localparam logic [6:0] CONV_LAST = 7'(CONV_CYC - 1);
	typedef enum logic [1:0] {ST_IDLE, ST_CONV} acwl_state_t;
endpackage

// [acwl_sync.sv]
/*
 Two-stage synchroniser for one level.
 Assumes input asynchronous to clock.
*/
`timescale 1ns/100ps
module acwl_sync (
	input  wire logic clock,
	input  wire logic reset_n,
	input  wire logic async_in,
	output logic      sync_out
);
	typedef struct packed {
		logic s1;
		logic s2;
	} acwl_sync_t;
	acwl_sync_t st_ff, nxt_st;
	always_comb begin
		nxt_st    = st_ff;
		nxt_st.s1 = async_in;
		nxt_st.s2 = st_ff.s1;
	end
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end
	assign sync_out = st_ff.s2;
endmodule

// [acwl_decode.sv]
/*
 Decodes an active setup word into plain steering levels.
 Assumes word is stable between conversions.
*/
`timescale 1ns/100ps
module acwl_decode (
	input  wire logic [13:0] word,
	output logic             paired,
	output logic             bipolar,
	output logic             temp_route,
	output logic             com_used,
	output logic             full_width,
	output logic             ref_internal,
	output logic             ref_4v096,
	output logic             ref_buffered,
	output logic             temp_on,
	output logic             echo_en
);
	logic [2:0] arr;
	logic [2:0] refs;
	always_comb begin
		arr          = word[acwl_pkg::ARR_HI:acwl_pkg::ARR_LO];
		refs         = word[acwl_pkg::REF_HI:acwl_pkg::REF_LO];
		paired       = (arr[1] == 1'b0);
		bipolar      = (arr[2] == 1'b0) && (arr != acwl_pkg::ARR_TEMP);
		temp_route   = (arr == acwl_pkg::ARR_TEMP);
		com_used     = (arr == acwl_pkg::ARR_BI_COM) || (arr == acwl_pkg::ARR_UNI_COM);
		full_width   = word[acwl_pkg::FW_BIT];
		ref_internal = (refs[2:1] == 2'h0);
		ref_4v096    = (refs == 3'h1);
		ref_buffered = (refs[1] == 1'b1) && refs[0];
		temp_on      = !refs[2];
		echo_en      = !word[acwl_pkg::ECHO_BIT];
	end
endmodule

// [acwl_loader.sv]
/*
 Setup word loader: serial shift-in, end-of-conversion commit, scan stepping.
 Assumes serial clock, data and convert_start are asynchronous pins.
*/
// Operation
// - Word shifts in MSB first on rising clock
// - Settings commit only at conversion end
// - New word governs the following conversion
// - Data held high loads all-ones word
// - Top bit zero keeps present settings
// - Arrangement codes pick pairs, temperature, polarity
// - Code 111 single-ended against ground
// - Code 110 unipolar against common input
// - Code 010 bipolar against half-reference common
// - Paired modes: channel names positive input
// - Bit 6 picks full or reduced bandwidth
// - Reference field selects reference and sensor
// - Scan 00 off, 01 updates mid-sequence
// - Scan 11 steps to channel; 10 adds temperature
// - Bit 0 low appends word after result
// - Convert input starts internally timed conversion
// - Reduced bandwidth is one quarter full
`timescale 1ns/100ps
module acwl_loader (
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic        serial_clk,
	input  wire logic        serial_din,
	input  wire logic        convert_start,
	output logic [13:0]      converter_setup_word,
	output logic             busy,
	output logic             conv_done,
	output logic [2:0]       conv_channel,
	output logic             conv_temp,
	output logic [2:0]       input_arrangement,
	output logic             filter_width,
	output logic [2:0]       ref_select,
	output logic [1:0]       scan_control,
	output logic             echo_setup,
	output logic             paired_mode,
	output logic             bipolar_mode,
	output logic             common_input_used,
	output logic             temp_sensor_on
);
	typedef struct packed {
		acwl_pkg::acwl_state_t state;
		logic                  sck_d;
		logic [13:0]           shift;
		logic [3:0]            nbits;
		logic [13:0]           active;
		logic                  din_all_high;
		logic [6:0]            timer;
		logic                  done;
		logic [2:0]            chan;
		logic                  temp;
		logic [2:0]            seq_idx;
		logic                  seq_temp;
		logic                  seq_run;
		logic                  paired;
		logic                  bipolar;
		logic                  common_input;
		logic                  tsens;
		logic                  busy;
		logic                  echo;
	} acwl_st_t;

	acwl_st_t   st_ff, nxt_st;
	logic       sck_s;
	logic       din_s;
	logic       cnv_s;
	logic       cnv_d_ff;
	logic       d_paired;
	logic       d_bipolar;
	logic       d_temp_route;
	logic       d_com;
	logic       d_tsens;
	logic       d_echo;
	logic [13:0] cand;
	logic [2:0]  last_ch;
	logic [1:0]  scn;

	acwl_sync u_sck (.clock(clock), .reset_n(reset_n), .async_in(serial_clk), .sync_out(sck_s));
	acwl_sync u_din (.clock(clock), .reset_n(reset_n), .async_in(serial_din), .sync_out(din_s));
	acwl_sync u_cnv (.clock(clock), .reset_n(reset_n), .async_in(convert_start), .sync_out(cnv_s));

	acwl_decode u_dec (
		.word        (nxt_st.active),
		.paired      (d_paired),
		.bipolar     (d_bipolar),
		.temp_route  (d_temp_route),
		.com_used    (d_com),
		.full_width  (),
		.ref_internal(),
		.ref_4v096   (),
		.ref_buffered(),
		.temp_on     (d_tsens),
		.echo_en     (d_echo)
	);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			cnv_d_ff <= 1'b0;
		else
			cnv_d_ff <= cnv_s;
	end

	always_comb begin
		nxt_st      = st_ff;
		nxt_st.done = 1'b0;
		nxt_st.sck_d = sck_s;
		cand        = st_ff.active;
		last_ch     = st_ff.active[acwl_pkg::CH_HI:acwl_pkg::CH_LO];
		scn         = st_ff.active[acwl_pkg::SCAN_HI:acwl_pkg::SCAN_LO];
		// Bits are taken on rising serial edges until 14 are held, MSB first
		if (sck_s && !st_ff.sck_d && (st_ff.nbits <= acwl_pkg::BITS_LAST)) begin
			nxt_st.shift = {st_ff.shift[12:0], din_s};
			nxt_st.nbits = st_ff.nbits + 4'h1;
		end
		// One low sample during the conversion rules out the default load
		if (!din_s)
			nxt_st.din_all_high = 1'b0;
		case (st_ff.state)
			acwl_pkg::ST_IDLE: begin
				if (cnv_s && !cnv_d_ff) begin
					nxt_st.state        = acwl_pkg::ST_CONV;
					nxt_st.timer        = '0;
					nxt_st.din_all_high = din_s;
				end
			end
			acwl_pkg::ST_CONV: begin
				nxt_st.timer = st_ff.timer + 7'h1;
				if (st_ff.timer == acwl_pkg::CONV_LAST) begin
					nxt_st.state = acwl_pkg::ST_IDLE;
					nxt_st.done  = 1'b1;
					// Partial words are discarded; host must finish in time
					if (st_ff.din_all_high && din_s)
						cand = acwl_pkg::DEFAULT_WORD;
					else if ((st_ff.nbits == 4'(acwl_pkg::WORD_W))
							&& st_ff.shift[acwl_pkg::QUAL_BIT])
						cand = st_ff.shift;
					nxt_st.active = cand;
					nxt_st.nbits  = acwl_pkg::BITS_ZERO;
					// Sequencer stops, holds or restarts at input 0; mid-sequence update keeps position
					if (cand[acwl_pkg::SCAN_HI:acwl_pkg::SCAN_LO] == acwl_pkg::SCAN_OFF) begin
						nxt_st.seq_run = 1'b0;
					end else if (cand[acwl_pkg::SCAN_HI:acwl_pkg::SCAN_LO] == acwl_pkg::SCAN_UPD
							&& st_ff.seq_run) begin
						nxt_st.seq_run = 1'b1;
					end else if (cand[acwl_pkg::SCAN_HI] && (cand != st_ff.active
							|| !st_ff.seq_run)) begin
						nxt_st.seq_run  = 1'b1;
						nxt_st.seq_idx  = acwl_pkg::CH_ZERO;
						nxt_st.seq_temp = 1'b0;
					end
				end
			end
			default: nxt_st.state = acwl_pkg::ST_IDLE;
		endcase
		// Advance sequence position for the next conversion once one has started
		if (st_ff.state == acwl_pkg::ST_CONV && st_ff.timer == '0 && st_ff.seq_run) begin
			if (st_ff.seq_temp || (st_ff.seq_idx >= last_ch && scn != acwl_pkg::SCAN_TEMP)) begin
				nxt_st.seq_idx  = acwl_pkg::CH_ZERO;
				nxt_st.seq_temp = 1'b0;
			end else if (st_ff.seq_idx >= last_ch) begin
				nxt_st.seq_temp = 1'b1;
			end else begin
				nxt_st.seq_idx = st_ff.seq_idx + (d_paired ? 3'h2 : 3'h1);
			end
		end
		// Channel applied for a conversion comes from the sequencer when scanning, else from active settings
		if (st_ff.state == acwl_pkg::ST_IDLE && cnv_s && !cnv_d_ff) begin
			if (st_ff.seq_run) begin
				nxt_st.chan = st_ff.seq_idx;
				nxt_st.temp = st_ff.seq_temp;
			end else begin
				nxt_st.chan = last_ch;
				nxt_st.temp = (st_ff.active[acwl_pkg::ARR_HI:acwl_pkg::ARR_LO]
					== acwl_pkg::ARR_TEMP);
			end
		end
		nxt_st.paired  = d_paired;
		nxt_st.bipolar = d_bipolar;
		nxt_st.common_input     = d_com && !d_temp_route;
		nxt_st.tsens   = d_tsens;
		// Registered so both pins come straight from flops
		nxt_st.busy    = (nxt_st.state == acwl_pkg::ST_CONV);
		nxt_st.echo    = d_echo;
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			st_ff        <= '0;
			st_ff.active <= acwl_pkg::RESET_WORD;
			// Read-back flag follows the reset word
			st_ff.echo   <= !acwl_pkg::RESET_WORD[acwl_pkg::ECHO_BIT];
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign converter_setup_word = st_ff.active;
	assign busy                 = st_ff.busy;
	assign conv_done            = st_ff.done;
	assign conv_channel         = st_ff.chan;
	assign conv_temp            = st_ff.temp;
	assign input_arrangement    = st_ff.active[acwl_pkg::ARR_HI:acwl_pkg::ARR_LO];
	assign filter_width         = st_ff.active[acwl_pkg::FW_BIT];
	assign ref_select           = st_ff.active[acwl_pkg::REF_HI:acwl_pkg::REF_LO];
	assign scan_control         = st_ff.active[acwl_pkg::SCAN_HI:acwl_pkg::SCAN_LO];
	assign echo_setup           = st_ff.echo;
	assign paired_mode          = st_ff.paired;
	assign bipolar_mode         = st_ff.bipolar;
	assign common_input_used    = st_ff.common_input;
	assign temp_sensor_on       = st_ff.tsens;

	// Settings move only on the conversion-end edge
	commit_only_end_a: assert property (@(posedge clock) disable iff (!reset_n)
		(st_ff.state == acwl_pkg::ST_IDLE) |=> $stable(st_ff.active))
		else $error("setup word changed outside conversion end");
	done_at_end_a: assert property (@(posedge clock) disable iff (!reset_n)
		conv_done |-> !busy && $past(busy))
		else $error("done pulse away from conversion end");
	end_has_done_a: assert property (@(posedge clock) disable iff (!reset_n)
		$fell(busy) |-> conv_done)
		else $error("conversion ended without done pulse");
	count_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
		conv_done |-> (st_ff.nbits == acwl_pkg::BITS_ZERO))
		else $error("bit count not cleared at conversion end");

	// Conversion timing and the channel it uses
	conv_length_a: assert property (@(posedge clock) disable iff (!reset_n)
		$rose(busy) |-> busy [*8])
		else $error("conversion ended too early");
	timer_range_a: assert property (@(posedge clock) disable iff (!reset_n)
		busy |-> (st_ff.timer <= acwl_pkg::CONV_LAST))
		else $error("conversion timer overran");
	chan_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
		busy && $past(busy) |-> $stable(conv_channel) && $stable(conv_temp))
		else $error("channel moved during conversion");
	temp_chan_a: assert property (@(posedge clock) disable iff (!reset_n)
		$rose(busy) && !st_ff.seq_run && !$past(st_ff.seq_run)
		|-> conv_temp == (input_arrangement == acwl_pkg::ARR_TEMP))
		else $error("temperature routing wrong");

	// Serial shift-in and commit of a complete word
	shift_order_a: assert property (@(posedge clock) disable iff (!reset_n)
		(sck_s && !st_ff.sck_d && st_ff.nbits <= acwl_pkg::BITS_LAST)
		|=> st_ff.shift[0] == $past(din_s) && st_ff.shift[13:1] == $past(st_ff.shift[12:0]))
		else $error("serial bit not shifted in MSB first");
	bit_count_a: assert property (@(posedge clock) disable iff (!reset_n)
		st_ff.nbits <= 4'(acwl_pkg::WORD_W))
		else $error("bit count overran");
	keep_on_zero_a: assert property (@(posedge clock) disable iff (!reset_n)
		(nxt_st.done && !st_ff.din_all_high && !st_ff.shift[acwl_pkg::QUAL_BIT])
		|=> $stable(st_ff.active))
		else $error("qualifier zero but word changed");
	default_load_a: assert property (@(posedge clock) disable iff (!reset_n)
		(nxt_st.done && st_ff.din_all_high && din_s) |=> (st_ff.active == acwl_pkg::DEFAULT_WORD))
		else $error("all-ones default not loaded");
	load_word_a: assert property (@(posedge clock) disable iff (!reset_n)
		(nxt_st.done && !st_ff.din_all_high && st_ff.nbits == 4'(acwl_pkg::WORD_W)
		&& st_ff.shift[acwl_pkg::QUAL_BIT]) |=> (st_ff.active == $past(st_ff.shift)))
		else $error("complete qualified word not committed");

	// Decoded levels follow the active word; all register on the same edge
	echo_map_a: assert property (@(posedge clock) disable iff (!reset_n)
		echo_setup == !converter_setup_word[acwl_pkg::ECHO_BIT])
		else $error("echo flag wrong");
	pair_map_a: assert property (@(posedge clock) disable iff (!reset_n)
		paired_mode == (input_arrangement[1] == 1'b0))
		else $error("paired mode decode wrong");
	common_map_a: assert property (@(posedge clock) disable iff (!reset_n)
		common_input_used == (input_arrangement == acwl_pkg::ARR_BI_COM
		|| input_arrangement == acwl_pkg::ARR_UNI_COM))
		else $error("common input decode wrong");
	single_ground_a: assert property (@(posedge clock) disable iff (!reset_n)
		(input_arrangement == acwl_pkg::ARR_SINGLE) |-> !common_input_used && !bipolar_mode)
		else $error("single-ended decode wrong");
	sensor_map_a: assert property (@(posedge clock) disable iff (!reset_n)
		temp_sensor_on == !ref_select[2])
		else $error("sensor enable decode wrong");

	// Sequencer response to a committed scan field
	scan_off_a: assert property (@(posedge clock) disable iff (!reset_n)
		(nxt_st.done && cand[acwl_pkg::SCAN_HI:acwl_pkg::SCAN_LO] == acwl_pkg::SCAN_OFF)
		|=> !st_ff.seq_run)
		else $error("scan off left sequence running");
	scan_update_a: assert property (@(posedge clock) disable iff (!reset_n)
		(nxt_st.done && st_ff.seq_run && cand[acwl_pkg::SCAN_HI:acwl_pkg::SCAN_LO]
		== acwl_pkg::SCAN_UPD) |=> st_ff.seq_run && $stable(st_ff.seq_idx))
		else $error("scan update stopped or moved the sequence");

	conv_seen_c: cover property (@(posedge clock) disable iff (!reset_n) conv_done);
	load_seen_c: cover property (@(posedge clock) disable iff (!reset_n)
		nxt_st.done && st_ff.nbits == 4'(acwl_pkg::WORD_W));
	scan_seen_c: cover property (@(posedge clock) disable iff (!reset_n) st_ff.seq_temp);
	default_seen_c: cover property (@(posedge clock) disable iff (!reset_n)
		nxt_st.done && st_ff.din_all_high && din_s);
	update_seen_c: cover property (@(posedge clock) disable iff (!reset_n)
		nxt_st.done && st_ff.seq_run && cand[acwl_pkg::SCAN_HI:acwl_pkg::SCAN_LO] == acwl_pkg::SCAN_UPD);
endmodule

// [acwl_host.sv]
/*
 Host model for the setup word loader: serial clock, serial data, convert pin.
 Assumes a free-running system clock; pins change only at its falling edge.
*/
`timescale 1ns/100ps
module acwl_host (
	input  wire logic clock,
	output logic      serial_clk,
	output logic      serial_din,
	output logic      convert_start
);
	// Serial clock stands low outside frames
	initial begin
		serial_clk = 1'b0;
		serial_din = 1'b0;
		convert_start = 1'b0;
	end
	// Top n bits of w, MSB first; half = clocks per half period
	task automatic shift_bits(input logic [13:0] w, input int n, input int half);
		for (int i = 13; i > 13 - n; i--) begin
			@(negedge clock);
			serial_din = w[i];
			repeat (half) @(negedge clock);
			serial_clk = 1'b1;
			repeat (half) @(negedge clock);
			serial_clk = 1'b0;
		end
		// Held low after a frame so no new load starts
		@(negedge clock);
		serial_din = 1'b0;
	endtask
	task automatic drive_din(input logic v);
		@(negedge clock);
		serial_din = v;
	endtask
	task automatic drive_convert(input logic v);
		@(negedge clock);
		convert_start = v;
	endtask
endmodule

// [tb_adc_config_word_loader.sv]
/*
 Self-checking bench for the setup word loader.
 Assumes acwl_pkg, acwl_loader and acwl_host are compiled first.
*/
`timescale 1ns/100ps
module tb_adc_config_word_loader;
	logic        clock, reset_n, serial_clk, serial_din, convert_start;
	logic [13:0] word;
	logic        busy, conv_done, conv_temp, fw, echo, paired, bip, common_input, tmp;
	logic [2:0]  conv_channel, arr, rsel, ch;
	logic [1:0]  scan;
	logic        t;
	int          err_total, num_checks;
	acwl_loader i_dut (.clock(clock), .reset_n(reset_n), .serial_clk(serial_clk),
		.serial_din(serial_din), .convert_start(convert_start),
		.converter_setup_word(word), .busy(busy), .conv_done(conv_done),
		.conv_channel(conv_channel), .conv_temp(conv_temp), .input_arrangement(arr),
		.filter_width(fw), .ref_select(rsel), .scan_control(scan), .echo_setup(echo),
		.paired_mode(paired), .bipolar_mode(bip), .common_input_used(common_input),
		.temp_sensor_on(tmp));
	acwl_host i_host (.clock(clock), .serial_clk(serial_clk), .serial_din(serial_din),
		.convert_start(convert_start));
	initial clock = 1'b0;
	always #20 clock = ~clock;
	task automatic check(input logic ok, input string msg);
		num_checks++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask
	// Second convert while busy must be ignored
	task automatic run_conv(output logic [2:0] c, output logic tp);
		int n;
		n = 0;
		i_host.drive_convert(1'b1);
		while (busy !== 1'b1 && n < 10) begin
			@(negedge clock);
			n++;
		end
		i_host.drive_convert(1'b0);
		c = conv_channel;
		tp = conv_temp;
		n = 0;
		while (busy === 1'b1 && n < 100) begin
			if (n == 20) i_host.drive_convert(1'b1);
			else if (n == 30) i_host.drive_convert(1'b0);
			else @(negedge clock);
			n++;
		end
		// First busy cycle passes while the pin is released
		check(n == acwl_pkg::CONV_CYC - 1, "busy length");
		check(conv_done === 1'b1, "done pulse at end");
		repeat (2) @(negedge clock);
		check(busy === 1'b0, "convert while busy ignored");
	endtask
	task automatic load(input logic [13:0] w, output logic [2:0] c);
		i_host.shift_bits(w, 14, 4);
		run_conv(c, t);
	endtask
	task automatic t_lag();
		logic [13:0] w1, w2;
		w1 = {1'b1, 3'h7, 3'h5, 1'b0, 3'h1, 2'h0, 1'b0};
		w2 = {1'b1, 3'h7, 3'h2, 1'b1, 3'h6, 2'h0, 1'b1};
		load(w1, ch);
		check(word === w1, "word w1 committed");
		load(w2, ch);
		check(ch === 3'h5, "old channel used");
		check(word === w2, "word w2 committed");
		run_conv(ch, t);
		check(ch === 3'h2, "binary channel");
		load({1'b0, 13'h0}, ch);
		check(word === w2, "qualifier low keeps");
		i_host.shift_bits(w1, 7, 4);
		run_conv(ch, t);
		check(word === w2, "partial word dropped");
		i_host.drive_din(1'b1);
		run_conv(ch, t);
		i_host.drive_din(1'b0);
		check(word === acwl_pkg::DEFAULT_WORD, "din high default");
	endtask
	task automatic t_fields();
		logic [2:0] rs [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7, 3'h0, 3'h1};
		logic [2:0] c;
		for (int i = 0; i < 8; i++) begin
			c = 3'(i);
			load({1'b1, c, 3'h0, c[0], rs[i], 2'h0, ~c[0]}, ch);
			check(arr === c, "arrangement field");
			check(paired === ~c[1], "paired decode");
			if (c != 3'h3) check(bip === ~c[2], "bipolar decode");
			check(common_input === (c == 3'h2 || c == 3'h6), "common input");
			check(fw === c[0], "filter width");
			check(rsel === rs[i] && tmp === ~rs[i][2], "reference");
			check(echo === c[0] && scan === 2'h0, "echo and scan");
		end
	endtask
	task automatic t_scan();
		load({1'b1, 3'h7, 3'h2, 1'b1, 3'h6, 2'h2, 1'b1}, ch);
		for (int i = 0; i < 4; i++) begin
			run_conv(ch, t);
			if (i < 3) check(ch === 3'(i) && t === 1'b0, "scan step");
			else check(t === 1'b1, "scan temperature step");
		end
		// Update mid-sequence keeps the scan position
		load({1'b1, 3'h7, 3'h2, 1'b1, 3'h6, 2'h1, 1'b1}, ch);
		check(ch === 3'h0 && scan === 2'h1, "scan wrapped after temperature");
		run_conv(ch, t);
		check(ch === 3'h1, "update kept position");
		// New scan word restarts at input 0 and skips the sensor
		load({1'b1, 3'h7, 3'h1, 1'b1, 3'h6, 2'h3, 1'b1}, ch);
		for (int i = 0; i < 3; i++) begin
			run_conv(ch, t);
			check(ch === 3'(i % 2) && t === 1'b0, "plain scan step");
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		err_total = 0;
		num_checks = 0;
		reset_n = 1'b0;
		repeat (2) @(negedge clock);
		reset_n = 1'b1;
		@(negedge clock);
		check(word === acwl_pkg::RESET_WORD && busy === 1'b0, "reset state");
		run_conv(ch, t);
		check(word === acwl_pkg::RESET_WORD, "dummy conversion keeps");
		t_lag();
		t_fields();
		t_scan();
		results();
	end
	// Run needs about 3400 cycles; limit leaves wide margin
	initial begin
		#400000;
		err_total++;
		results();
	end
endmodule
